// >>> verilog/bcr_pkg.sv
// shared constants for the board control register file
// Behaviour
// RQ1: channel disable bit gates card input buffers
// RQ2: channel disabled tri-states the speaker buffer
// RQ3: card strobe/data buffers drive only when powered
// RQ4: card seated: read sense, then apply supply
// RQ5: card removed: controller may cut supply
// RQ6: check sense before supply; no 5V misuse
// RQ7: 32-bit registers, content on upper sixteen lines
// RQ8: five registers alias across the select region
// RQ9: disable bit wakes enabled, writable only unlocked
// RQ10: any control-one write re-arms the guard
// RQ11: once disabled, only power cycle recovers
// RQ12: configuration register at offset zero, read/write
// RQ13: configuration defaults load on power-on only
// RQ14: drive configuration during hard reset unless flash
// RQ15: new configuration used at next hard reset
// RQ16: control register one at byte offset four
// RQ17: reserved configuration bits store and drive
// RQ18: lower sixteen lines read zero, writes ignored
// RQ19: module enables also routed to expansion pins
package bcr_pkg;
	localparam int unsigned BCR_ADDR_W = 15;
	localparam int unsigned BCR_DATA_W = 32;
	localparam int unsigned BCR_HALF_W = 16;
	localparam int unsigned BCR_NUM_REGS = 5;
	localparam int unsigned BCR_MOD_W = 4;

	// register byte offsets
	localparam logic [14:0] BCR_OFF_CONFIG = 15'h0000;
	localparam logic [14:0] BCR_OFF_CTRL1 = 15'h0004;
	localparam logic [14:0] BCR_OFF_STATUS2 = 15'h0008;
	localparam logic [14:0] BCR_OFF_CTRL3 = 15'h000c;
	localparam logic [14:0] BCR_OFF_SPARE4 = 15'h0010;

	// power-on values of the upper sixteen lines
	localparam logic [15:0] BCR_RST_CONFIG = 16'h0160;
	localparam logic [15:0] BCR_RST_CTRL1 = 16'h6000;
	localparam logic [15:0] BCR_RST_CTRL3 = 16'h0000;

	// control register one fields, 32-bit bit positions
	localparam int unsigned BCR_C1_REGF_DIS = 31;
	localparam int unsigned BCR_C1_CHAN_DIS = 30;
	localparam int unsigned BCR_C1_FLASH_CFG = 29;
	localparam int unsigned BCR_C1_SUPPLY_LSB = 27;
	localparam int unsigned BCR_C1_MOD_LSB = 23;
	// status register two fields
	localparam int unsigned BCR_S2_DETECT_LSB = 30;
	localparam int unsigned BCR_S2_SENSE_LSB = 28;
	// control register three fields
	localparam int unsigned BCR_C3_GUARD = 31;

	// card supply codes
	localparam logic [1:0] BCR_SUPPLY_OFF = 2'h0;
	localparam logic [1:0] BCR_SUPPLY_5V = 2'h1;

	// controller software register offsets
	localparam logic [7:0] BCR_SW_CTRL = 8'h00;
	localparam logic [7:0] BCR_SW_ADDR = 8'h04;
	localparam logic [7:0] BCR_SW_WDATA = 8'h08;
	localparam logic [7:0] BCR_SW_CMD = 8'h0c;
	localparam logic [7:0] BCR_SW_RDATA = 8'h10;
	localparam logic [7:0] BCR_SW_STATUS = 8'h14;
	localparam logic [7:0] BCR_SW_IRQ_STAT = 8'h18;
	localparam logic [7:0] BCR_SW_IRQ_CLR = 8'h1c;
	localparam logic [7:0] BCR_SW_IRQ_EN = 8'h20;
	localparam int unsigned BCR_CTRL_AUTO = 0;
	localparam int unsigned BCR_CTRL_HRESET = 1;
	localparam int unsigned BCR_CMD_GO = 0;
	localparam int unsigned BCR_CMD_WR = 1;
	localparam int unsigned BCR_EV_W = 4;
	localparam int unsigned BCR_EV_DONE = 0;
	localparam int unsigned BCR_EV_POWERED = 1;
	localparam int unsigned BCR_EV_UNPOWERED = 2;
	localparam int unsigned BCR_EV_REFUSED = 3;
	localparam int unsigned BCR_POLL_CYCLES = 1000;
endpackage : bcr_pkg

// >>> verilog/bcr_if.sv
// local bus between controller and board control register file
`timescale 1ns/1ps
`default_nettype none
interface bcr_if;
	logic cs;
	logic [14:0] addr;
	logic we;
	logic re;
	logic [31:0] wdata;
	logic hreset;
	logic [31:0] dev_data;
	logic dev_oe;

	modport dev (
		input cs, addr, we, re, wdata, hreset,
		output dev_data, dev_oe
	);
	modport host (
		output cs, addr, we, re, wdata, hreset,
		input dev_data, dev_oe
	);
endinterface : bcr_if
`default_nettype wire

// >>> verilog/bcr_dev.sv
// board control register file: device end of the local bus
`timescale 1ns/1ps
`default_nettype none
module bcr_dev #(
	parameter int unsigned ADDR_W = bcr_pkg::BCR_ADDR_W
) (
	// clock and main power-on reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// local bus
	bcr_if.dev bus,
	// card socket pins
	input wire logic [1:0] i_card_detect_n,
	input wire logic [1:0] i_voltage_sense_n,
	// card port buffer controls
	output logic o_card_in_buf_en,
	output logic o_speaker_oe,
	output logic o_card_strobe_oe,
	output logic [1:0] o_card_supply_select,
	// module enables towards expansion pins
	output logic [3:0] o_module_en_n,
	output logic o_regfile_disable_n
);
	initial begin
		if (ADDR_W < 5 || ADDR_W > 15) begin
			$error("bcr_dev: ADDR_W must be 5 to 15");
		end
	end

	// register index from the word address, upper bits dropped
	function automatic logic [2:0] reg_index(input logic [14:0] a);
		reg_index = a[4:2]; // RQ8
	endfunction : reg_index

	localparam logic [2:0] IDX_CONFIG = bcr_pkg::BCR_OFF_CONFIG[4:2];
	localparam logic [2:0] IDX_CTRL1 = bcr_pkg::BCR_OFF_CTRL1[4:2];
	localparam logic [2:0] IDX_STATUS2 = bcr_pkg::BCR_OFF_STATUS2[4:2];
	localparam logic [2:0] IDX_CTRL3 = bcr_pkg::BCR_OFF_CTRL3[4:2];
	localparam logic [2:0] IDX_SPARE4 = bcr_pkg::BCR_OFF_SPARE4[4:2];
	localparam int unsigned H = bcr_pkg::BCR_HALF_W;

	logic [15:0] config_q;
	logic [15:0] ctrl1_q;
	logic guard_q;
	logic [1:0] detect_meta_q;
	logic [1:0] detect_q;
	logic [1:0] sense_meta_q;
	logic [1:0] sense_q;
	logic [31:0] dev_data_q;
	logic dev_oe_q;
	logic regfile_on;
	logic [2:0] idx;
	logic wr_hit;
	logic rd_hit;
	logic [15:0] wr_hi;
	logic [15:0] rd_hi;
	logic [15:0] status2;
	logic [15:0] ctrl1_d;

	// disabled register file answers nothing
	assign regfile_on = ~ctrl1_q[bcr_pkg::BCR_C1_REGF_DIS - H]; // RQ11
	assign idx = reg_index(bus.addr[14:0]);
	assign wr_hit = bus.cs & bus.we & regfile_on;
	assign rd_hit = bus.cs & bus.re & regfile_on;
	// lower sixteen lines never stored
	assign wr_hi = bus.wdata[31:16]; // RQ18

	// socket pins come from outside the clock domain
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			detect_meta_q <= 2'h3;
			detect_q <= 2'h3;
			sense_meta_q <= 2'h3;
			sense_q <= 2'h3;
		end else begin
			detect_meta_q <= i_card_detect_n;
			detect_q <= detect_meta_q;
			sense_meta_q <= i_voltage_sense_n;
			sense_q <= sense_meta_q;
		end
	end

	always_comb begin
		status2 = 16'h0000;
		status2[bcr_pkg::BCR_S2_DETECT_LSB - H +: 2] = detect_q;
		status2[bcr_pkg::BCR_S2_SENSE_LSB - H +: 2] = sense_q;
	end

	// configuration word, power-on defaults only, every bit kept
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			config_q <= bcr_pkg::BCR_RST_CONFIG; // RQ13
		end else if (wr_hit && idx == IDX_CONFIG) begin
			config_q <= wr_hi; // RQ12 RQ17
		end
	end

	// control register one; disable bit held unless unlocked
	always_comb begin
		ctrl1_d = wr_hi;
		if (!guard_q) begin
			ctrl1_d[bcr_pkg::BCR_C1_REGF_DIS - H] = ctrl1_q[bcr_pkg::BCR_C1_REGF_DIS - H]; // RQ9
		end
		if (!regfile_on) begin
			ctrl1_d[bcr_pkg::BCR_C1_REGF_DIS - H] = 1'b1; // RQ11
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctrl1_q <= bcr_pkg::BCR_RST_CTRL1; // RQ9
		end else if (wr_hit && idx == IDX_CTRL1) begin
			ctrl1_q <= ctrl1_d; // RQ16
		end
	end

	// one-shot unlock of the disable bit
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			guard_q <= bcr_pkg::BCR_RST_CTRL3[bcr_pkg::BCR_C3_GUARD - H];
		end else if (wr_hit && idx == IDX_CTRL1) begin
			guard_q <= 1'b0; // RQ10
		end else if (wr_hit && idx == IDX_CTRL3) begin
			guard_q <= wr_hi[bcr_pkg::BCR_C3_GUARD - H]; // RQ9
		end
	end

	always_comb begin
		rd_hi = 16'h0000;
		case (idx)
			IDX_CONFIG: begin
				rd_hi = config_q;
			end
			IDX_CTRL1: begin
				rd_hi = ctrl1_q;
			end
			IDX_STATUS2: begin
				rd_hi = status2;
			end
			IDX_CTRL3: begin
				rd_hi[bcr_pkg::BCR_C3_GUARD - H] = guard_q;
			end
			IDX_SPARE4: begin
				rd_hi = 16'h0000;
			end
			default: begin
				rd_hi = 16'h0000;
			end
		endcase
	end

	// data bus: read answer one cycle later, configuration in hard reset
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dev_data_q <= 32'h0000_0000;
			dev_oe_q <= 1'b0;
		end else if (rd_hit) begin
			dev_data_q <= {rd_hi, 16'h0000}; // RQ7 RQ18
			dev_oe_q <= 1'b1;
		end else if (bus.hreset && ctrl1_q[bcr_pkg::BCR_C1_FLASH_CFG - H]) begin
			dev_data_q <= {config_q, 16'h0000}; // RQ14 RQ15 RQ17
			dev_oe_q <= 1'b1;
		end else begin
			dev_data_q <= 32'h0000_0000;
			dev_oe_q <= 1'b0;
		end
	end

	assign bus.dev_data = dev_data_q;
	assign bus.dev_oe = dev_oe_q;

	// card port buffer controls
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_card_in_buf_en <= 1'b0;
			o_speaker_oe <= 1'b0;
			o_card_strobe_oe <= 1'b0;
			o_card_supply_select <= bcr_pkg::BCR_SUPPLY_OFF;
		end else begin
			o_card_in_buf_en <= ~ctrl1_q[bcr_pkg::BCR_C1_CHAN_DIS - H]; // RQ1
			o_speaker_oe <= ~ctrl1_q[bcr_pkg::BCR_C1_CHAN_DIS - H]; // RQ2
			o_card_strobe_oe <= (ctrl1_q[bcr_pkg::BCR_C1_SUPPLY_LSB - H +: 2] != bcr_pkg::BCR_SUPPLY_OFF); // RQ3
			o_card_supply_select <= ctrl1_q[bcr_pkg::BCR_C1_SUPPLY_LSB - H +: 2];
		end
	end

	// enables mirrored to the expansion connector
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_module_en_n <= bcr_pkg::BCR_RST_CTRL1[bcr_pkg::BCR_C1_MOD_LSB - H +: 4];
			o_regfile_disable_n <= bcr_pkg::BCR_RST_CTRL1[bcr_pkg::BCR_C1_REGF_DIS - H];
		end else begin
			o_module_en_n <= ctrl1_q[bcr_pkg::BCR_C1_MOD_LSB - H +: 4]; // RQ19
			o_regfile_disable_n <= ctrl1_q[bcr_pkg::BCR_C1_REGF_DIS - H]; // RQ19
		end
	end
endmodule : bcr_dev
`default_nettype wire

// >>> verilog/bcr_master.sv
// single-access local bus engine used by the controller
`timescale 1ns/1ps
`default_nettype none
module bcr_master (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// access request
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [14:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic o_done,
	output logic [31:0] o_rdata,
	// bus side
	input wire logic [31:0] i_bus_data,
	output logic o_cs,
	output logic o_we,
	output logic o_re,
	output logic [14:0] o_addr,
	output logic [31:0] o_wdata
);
	typedef enum logic [1:0] {BM_IDLE, BM_STROBE, BM_CAPTURE} bcr_bm_st_t;
	bcr_bm_st_t st_q;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q <= BM_IDLE;
			o_cs <= 1'b0;
			o_we <= 1'b0;
			o_re <= 1'b0;
			o_addr <= 15'h0000;
			o_wdata <= 32'h0000_0000;
			o_done <= 1'b0;
			o_rdata <= 32'h0000_0000;
		end else begin
			o_done <= 1'b0;
			case (st_q)
				BM_IDLE: begin
					if (i_req) begin
						o_cs <= 1'b1;
						o_we <= i_wr;
						o_re <= ~i_wr;
						o_addr <= i_addr;
						o_wdata <= i_wdata; // RQ7
						st_q <= BM_STROBE;
					end
				end
				BM_STROBE: begin
					o_cs <= 1'b0;
					o_we <= 1'b0;
					o_re <= 1'b0;
					if (o_we) begin
						o_done <= 1'b1;
						st_q <= BM_IDLE;
					end else begin
						st_q <= BM_CAPTURE;
					end
				end
				BM_CAPTURE: begin
					o_rdata <= i_bus_data;
					o_done <= 1'b1;
					st_q <= BM_IDLE;
				end
				default: begin
					st_q <= BM_IDLE;
				end
			endcase
		end
	end
endmodule : bcr_master
`default_nettype wire

// >>> verilog/bcr_host.sv
// controller end: software port, card supply manager, hard reset
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bcr_host #(
	parameter int unsigned POLL_CYCLES = bcr_pkg::BCR_POLL_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// software register port
	input wire logic [7:0] i_sw_addr,
	input wire logic [31:0] i_sw_wdata,
	input wire logic i_sw_we,
	input wire logic i_sw_re,
	output logic [31:0] o_sw_rdata,
	output logic o_irq,
	// local bus
	bcr_if.host bus
);
	initial begin
		if (POLL_CYCLES < 2) begin
			$error("bcr_host: POLL_CYCLES must be at least 2");
		end
	end

	typedef enum logic [2:0] {HS_IDLE, HS_SW, HS_RD_CTRL, HS_RD_STAT, HS_WR_CTRL} bcr_hs_st_t;
	localparam int unsigned H = bcr_pkg::BCR_HALF_W;
	localparam int unsigned SUP = bcr_pkg::BCR_C1_SUPPLY_LSB;

	bcr_hs_st_t st_q;
	logic [1:0] ctrl_q;
	logic [14:0] acc_addr_q;
	logic [31:0] acc_wdata_q;
	logic [31:0] acc_rdata_q;
	logic sw_pend_q;
	logic sw_wr_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_en_q;
	logic [3:0] ev_q;
	logic [31:0] poll_cnt_q;
	logic poll_pend_q;
	logic [31:0] ctl_img_q;
	logic mreq_q;
	logic mwr_q;
	logic [14:0] maddr_q;
	logic [31:0] mwdata_q;
	logic mdone;
	logic [31:0] mrdata;
	logic go;
	logic busy;
	logic seated;
	logic [31:0] img_new;

	assign busy = (st_q != HS_IDLE) | sw_pend_q;
	assign go = i_sw_we && i_sw_addr == bcr_pkg::BCR_SW_CMD && i_sw_wdata[bcr_pkg::BCR_CMD_GO];
	assign seated = (mrdata[bcr_pkg::BCR_S2_DETECT_LSB +: 2] == 2'h0);

	bcr_master u_master (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_req(mreq_q),
		.i_wr(mwr_q),
		.i_addr(maddr_q),
		.i_wdata(mwdata_q),
		.o_done(mdone),
		.o_rdata(mrdata),
		.i_bus_data(bus.dev_data),
		.o_cs(bus.cs),
		.o_we(bus.we),
		.o_re(bus.re),
		.o_addr(bus.addr),
		.o_wdata(bus.wdata)
	);
	assign bus.hreset = ctrl_q[bcr_pkg::BCR_CTRL_HRESET];

	// software registers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= 2'h0;
			acc_addr_q <= 15'h0000;
			acc_wdata_q <= 32'h0000_0000;
			irq_en_q <= 4'h0;
		end else if (i_sw_we) begin
			case (i_sw_addr)
				bcr_pkg::BCR_SW_CTRL: ctrl_q <= i_sw_wdata[1:0];
				bcr_pkg::BCR_SW_ADDR: acc_addr_q <= i_sw_wdata[14:0];
				bcr_pkg::BCR_SW_WDATA: acc_wdata_q <= i_sw_wdata;
				bcr_pkg::BCR_SW_IRQ_EN: irq_en_q <= i_sw_wdata[3:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_sw_rdata <= 32'h0000_0000;
		end else if (i_sw_re) begin
			case (i_sw_addr)
				bcr_pkg::BCR_SW_CTRL: o_sw_rdata <= {30'h0000_0000, ctrl_q};
				bcr_pkg::BCR_SW_ADDR: o_sw_rdata <= {17'h00000, acc_addr_q};
				bcr_pkg::BCR_SW_WDATA: o_sw_rdata <= acc_wdata_q;
				bcr_pkg::BCR_SW_RDATA: o_sw_rdata <= acc_rdata_q;
				bcr_pkg::BCR_SW_STATUS: o_sw_rdata <= {28'h000_0000, ctl_img_q[SUP +: 2], 1'b0, busy};
				bcr_pkg::BCR_SW_IRQ_STAT: o_sw_rdata <= {28'h000_0000, irq_stat_q};
				bcr_pkg::BCR_SW_IRQ_EN: o_sw_rdata <= {28'h000_0000, irq_en_q};
				default: o_sw_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_sw_rdata <= 32'h0000_0000;
		end
	end

	// interrupt: new events win over a clear in the same cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			irq_stat_q <= 4'h0;
			o_irq <= 1'b0;
		end else begin
			if (i_sw_we && i_sw_addr == bcr_pkg::BCR_SW_IRQ_CLR) begin
				irq_stat_q <= (irq_stat_q & ~i_sw_wdata[3:0]) | ev_q;
			end else begin
				irq_stat_q <= irq_stat_q | ev_q;
			end
			o_irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// poll divider
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			poll_cnt_q <= 32'h0000_0000;
			poll_pend_q <= 1'b0;
		end else begin
			if (poll_cnt_q == POLL_CYCLES - 1) begin
				poll_cnt_q <= 32'h0000_0000;
			end else begin
				poll_cnt_q <= poll_cnt_q + 32'h0000_0001;
			end
			if (poll_cnt_q == POLL_CYCLES - 1 && ctrl_q[bcr_pkg::BCR_CTRL_AUTO]) begin
				poll_pend_q <= 1'b1;
			end else if (st_q == HS_IDLE && !sw_pend_q) begin
				poll_pend_q <= 1'b0;
			end
		end
	end

	// new control image with the supply field replaced
	function automatic logic [31:0] with_supply(input logic [31:0] img, input logic [1:0] s);
		with_supply = img;
		with_supply[SUP +: 2] = s;
	endfunction : with_supply

	always_comb begin
		img_new = ctl_img_q;
		if (seated && !ctl_img_q[bcr_pkg::BCR_C1_CHAN_DIS] && mrdata[bcr_pkg::BCR_S2_SENSE_LSB]) begin
			img_new = with_supply(ctl_img_q, bcr_pkg::BCR_SUPPLY_5V); // RQ4 RQ6
		end else if (!seated) begin
			img_new = with_supply(ctl_img_q, bcr_pkg::BCR_SUPPLY_OFF); // RQ5
		end
	end

	// access sequencer
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q <= HS_IDLE;
			sw_pend_q <= 1'b0;
			sw_wr_q <= 1'b0;
			acc_rdata_q <= 32'h0000_0000;
			ctl_img_q <= {bcr_pkg::BCR_RST_CTRL1, 16'h0000};
			ev_q <= 4'h0;
			mreq_q <= 1'b0;
			mwr_q <= 1'b0;
			maddr_q <= 15'h0000;
			mwdata_q <= 32'h0000_0000;
		end else begin
			ev_q <= 4'h0;
			mreq_q <= 1'b0;
			if (go && busy) begin
				ev_q[bcr_pkg::BCR_EV_REFUSED] <= 1'b1;
			end else if (go) begin
				sw_pend_q <= 1'b1;
				sw_wr_q <= i_sw_wdata[bcr_pkg::BCR_CMD_WR];
			end
			case (st_q)
				HS_IDLE: begin
					if (sw_pend_q) begin
						sw_pend_q <= 1'b0;
						mreq_q <= 1'b1;
						mwr_q <= sw_wr_q;
						maddr_q <= acc_addr_q;
						mwdata_q <= acc_wdata_q; // RQ7
						st_q <= HS_SW;
					end else if (poll_pend_q) begin
						mreq_q <= 1'b1;
						mwr_q <= 1'b0;
						maddr_q <= bcr_pkg::BCR_OFF_CTRL1;
						st_q <= HS_RD_CTRL;
					end
				end
				HS_SW: begin
					if (mdone) begin
						if (!mwr_q) begin
							acc_rdata_q <= mrdata;
						end
						ev_q[bcr_pkg::BCR_EV_DONE] <= 1'b1;
						st_q <= HS_IDLE;
					end
				end
				HS_RD_CTRL: begin
					if (mdone) begin
						ctl_img_q <= mrdata;
						mreq_q <= 1'b1;
						maddr_q <= bcr_pkg::BCR_OFF_STATUS2; // RQ6
						st_q <= HS_RD_STAT;
					end
				end
				HS_RD_STAT: begin
					if (mdone && img_new[SUP +: 2] != ctl_img_q[SUP +: 2]) begin
						mreq_q <= 1'b1;
						mwr_q <= 1'b1;
						maddr_q <= bcr_pkg::BCR_OFF_CTRL1;
						mwdata_q <= {img_new[31:16], 16'h0000};
						ctl_img_q <= img_new;
						ev_q[bcr_pkg::BCR_EV_POWERED] <= (img_new[SUP +: 2] != bcr_pkg::BCR_SUPPLY_OFF);
						ev_q[bcr_pkg::BCR_EV_UNPOWERED] <= (img_new[SUP +: 2] == bcr_pkg::BCR_SUPPLY_OFF);
						st_q <= HS_WR_CTRL;
					end else if (mdone) begin
						st_q <= HS_IDLE;
					end
				end
				HS_WR_CTRL: begin
					if (mdone) begin
						st_q <= HS_IDLE;
					end
				end
				default: begin
					st_q <= HS_IDLE;
				end
			endcase
		end
	end
endmodule : bcr_host
`default_nettype wire

// >>> dv/bcr_bus_sva.sv
// checker for the local bus between controller and register file
`timescale 1ns/1ps
`default_nettype none
module bcr_bus_sva (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// local bus
	input wire logic cs,
	input wire logic [14:0] addr,
	input wire logic we,
	input wire logic re,
	input wire logic [31:0] wdata,
	input wire logic hreset,
	input wire logic [31:0] dev_data,
	input wire logic dev_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic [15:0] cfg_q;
	logic guard_q;
	logic dis_q;
	logic flash_q;
	wire logic wr = cs && we && !dis_q;
	wire logic rd = cs && re;
	wire logic [2:0] idx = addr[4:2];
	// shadow of the configuration word
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) cfg_q <= bcr_pkg::BCR_RST_CONFIG;
		else if (wr && idx == 3'h0) cfg_q <= wdata[31:16];
	end
	// shadow of guard, disable and flash source
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			guard_q <= 1'b0;
			dis_q <= 1'b0;
			flash_q <= 1'b1;
		end else if (wr && idx == 3'h1) begin
			guard_q <= 1'b0;
			dis_q <= guard_q && wdata[31];
			flash_q <= wdata[29];
		end else if (wr && idx == 3'h3) begin
			guard_q <= wdata[31];
		end
	end
	property p_read_answer; rd && !dis_q |=> dev_oe; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_cfg_read; rd && !dis_q && idx == 3'h0 |=> dev_data[31:16] == $past(cfg_q); endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback differs");
	property p_low_zero; dev_oe |-> dev_data[15:0] == 16'h0; endproperty
	a_low_zero: assert property (p_low_zero) else $error("lower lines not zero");
	property p_unmapped; rd && !dis_q && idx > 3'h3 |=> dev_data == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("spare index not zero");
	property p_disabled; rd && dis_q && !hreset |=> !dev_oe; endproperty
	a_disabled: assert property (p_disabled) else $error("disabled file answered");
	property p_hr_drive; hreset && flash_q && !rd |=> dev_oe && dev_data[31:16] == $past(cfg_q); endproperty
	a_hr_drive: assert property (p_hr_drive) else $error("config not driven in hard reset");
	property p_hr_quiet; hreset && !flash_q && !rd |=> !dev_oe; endproperty
	a_hr_quiet: assert property (p_hr_quiet) else $error("driven with flash source");
	property p_oe_cause; dev_oe |-> $past(rd) || $past(hreset); endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("data driven without cause");
	property p_strobe; rd |-> !we; endproperty
	a_strobe: assert property (p_strobe) else $error("read and write together");
	c_cfg_read: cover property (rd && idx == 3'h0);
	c_hr_drive: cover property (hreset && flash_q);
	c_disabled: cover property (dis_q);
endmodule : bcr_bus_sva
`default_nettype wire

// >>> dv/board_control_status_regs_tb.sv
// testbench: controller and register file joined on the local bus
`timescale 1ns/1ps
`default_nettype none
module board_control_status_regs_tb;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] sw_addr = 8'h00;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_we = 1'b0;
	logic sw_re = 1'b0;
	logic [1:0] detect_n = 2'h3;
	logic [1:0] sense_n = 2'h3;
	logic [31:0] sw_rdata;
	logic irq, buf_en, spk_oe, strb_oe, rf_dis_n, irq_on;
	logic [1:0] supply;
	logic [3:0] mod_en_n;
	logic [31:0] rd_v, d;
	logic [14:0] a;
	int bad_count = 0;
	int n_compared = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	bcr_if bus ();
	bcr_dev u_bcr_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(bus), .i_card_detect_n(detect_n),
		.i_voltage_sense_n(sense_n), .o_card_in_buf_en(buf_en), .o_speaker_oe(spk_oe),
		.o_card_strobe_oe(strb_oe), .o_card_supply_select(supply), .o_module_en_n(mod_en_n),
		.o_regfile_disable_n(rf_dis_n));
	bcr_host #(.POLL_CYCLES(20)) u_bcr_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sw_addr(sw_addr),
		.i_sw_wdata(sw_wdata), .i_sw_we(sw_we), .i_sw_re(sw_re), .o_sw_rdata(sw_rdata), .o_irq(irq), .bus(bus));
	bcr_bus_sva u_bcr_bus_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .cs(bus.cs), .addr(bus.addr), .we(bus.we),
		.re(bus.re), .wdata(bus.wdata), .hreset(bus.hreset), .dev_data(bus.dev_data), .dev_oe(bus.dev_oe));
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask : chk_bit
	task automatic sw_wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge i_clk_sys);
		sw_addr <= ad;
		sw_wdata <= dt;
		sw_we <= 1'b1;
		@(posedge i_clk_sys);
		sw_we <= 1'b0;
	endtask : sw_wr
	task automatic sw_rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge i_clk_sys);
		sw_addr <= ad;
		sw_re <= 1'b1;
		@(posedge i_clk_sys);
		sw_re <= 1'b0;
		#1;
		dt = sw_rdata;
	endtask : sw_rd
	// one access on the local bus, finished by polling the done event
	task automatic dev_go(input logic [14:0] ad, input logic [31:0] dt, input logic w, output logic [31:0] r);
		logic [31:0] s;
		sw_wr(bcr_pkg::BCR_SW_ADDR, {17'h0, ad});
		sw_wr(bcr_pkg::BCR_SW_WDATA, dt);
		sw_wr(bcr_pkg::BCR_SW_CMD, {30'h0, w, 1'b1});
		s = 32'h0;
		for (int i = 0; i < 40 && s[0] !== 1'b1; i++) sw_rd(bcr_pkg::BCR_SW_IRQ_STAT, s);
		chk_bit(s[0], 1'b1);
		@(posedge i_clk_sys);
		#1;
		chk_bit(irq, irq_on);
		sw_wr(bcr_pkg::BCR_SW_IRQ_CLR, 32'h1);
		sw_rd(bcr_pkg::BCR_SW_RDATA, r);
	endtask : dev_go
	function automatic logic [31:0] c1(input logic dis, chan, fl, input logic [1:0] sup, input logic [3:0] men);
		return {dis, chan, fl, sup, men, 23'h0};
	endfunction : c1
	task automatic card(input logic [1:0] det, input logic [1:0] sns, input logic [1:0] exp);
		@(posedge i_clk_sys);
		detect_n <= det;
		sense_n <= sns;
		sw_wr(bcr_pkg::BCR_SW_CTRL, 32'h1);
		repeat (100) @(posedge i_clk_sys);
		sw_wr(bcr_pkg::BCR_SW_CTRL, 32'h0);
		repeat (20) @(posedge i_clk_sys);
		#1;
		chk_word({30'h0, supply}, {30'h0, exp});
		chk_bit(strb_oe, exp != 2'h0);
	endtask : card
	task automatic hr(input logic [15:0] cfg, input logic drv);
		sw_wr(bcr_pkg::BCR_SW_CTRL, 32'h2);
		repeat (4) @(posedge i_clk_sys);
		#1;
		chk_bit(bus.dev_oe, drv);
		if (drv) chk_word(bus.dev_data, {cfg, 16'h0});
		sw_wr(bcr_pkg::BCR_SW_CTRL, 32'h0);
		repeat (4) @(posedge i_clk_sys);
	endtask : hr
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		bad_count++;
		conclude();
	end
	initial begin
		irq_on = 1'b0;
		rd_v = $urandom(32'hfdde41e4);
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		dev_go(15'h0000, 32'h0, 1'b0, rd_v);
		chk_word(rd_v, 32'h01600000);
		sw_wr(bcr_pkg::BCR_SW_IRQ_EN, 32'h1);
		irq_on = 1'b1;
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			a = 15'($urandom) & 15'h7fe0;
			dev_go(a, d, 1'b1, rd_v);
			dev_go(a ^ 15'h2aa0, 32'h0, 1'b0, rd_v);
			chk_word(rd_v, {d[31:16], 16'h0});
		end
		dev_go(15'h0014, 32'h0, 1'b0, rd_v);
		chk_word(rd_v, 32'h0);
		sw_rd(bcr_pkg::BCR_SW_IRQ_CLR, rd_v);
		chk_word(rd_v, 32'h0);
		sw_wr(bcr_pkg::BCR_SW_IRQ_EN, 32'h0);
		irq_on = 1'b0;
		$display("test register access done");
		dev_go(15'h0004, c1(1'b0, 1'b0, 1'b1, 2'h0, 4'ha), 1'b1, rd_v);
		chk_bit(buf_en, 1'b1);
		chk_bit(spk_oe, 1'b1);
		chk_word({28'h0, mod_en_n}, 32'ha);
		card(2'h0, 2'h3, bcr_pkg::BCR_SUPPLY_5V);
		card(2'h3, 2'h3, bcr_pkg::BCR_SUPPLY_OFF);
		card(2'h0, 2'h2, bcr_pkg::BCR_SUPPLY_OFF);
		sw_rd(bcr_pkg::BCR_SW_IRQ_STAT, rd_v);
		chk_word(rd_v, 32'h6);
		// second go while the first is still running is refused
		sw_wr(bcr_pkg::BCR_SW_CMD, 32'h1);
		sw_wr(bcr_pkg::BCR_SW_CMD, 32'h1);
		repeat (10) @(posedge i_clk_sys);
		sw_rd(bcr_pkg::BCR_SW_IRQ_STAT, rd_v);
		chk_word(rd_v, 32'hf);
		sw_wr(bcr_pkg::BCR_SW_IRQ_CLR, 32'hf);
		dev_go(15'h0004, c1(1'b0, 1'b1, 1'b1, 2'h0, 4'h5), 1'b1, rd_v);
		chk_bit(buf_en, 1'b0);
		chk_bit(spk_oe, 1'b0);
		$display("test card port done");
		hr(d[31:16], 1'b1);
		dev_go(15'h0000, 32'h5a3c0000, 1'b1, rd_v);
		hr(16'h5a3c, 1'b1);
		dev_go(15'h0000, 32'h0, 1'b0, rd_v);
		chk_word(rd_v, 32'h5a3c0000);
		dev_go(15'h0004, c1(1'b0, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		hr(16'h0, 1'b0);
		$display("test hard reset done");
		dev_go(15'h0004, c1(1'b1, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		chk_bit(rf_dis_n, 1'b0);
		dev_go(15'h000c, 32'h80000000, 1'b1, rd_v);
		dev_go(15'h0004, c1(1'b0, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		dev_go(15'h0004, c1(1'b1, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		chk_bit(rf_dis_n, 1'b0);
		dev_go(15'h000c, 32'h80000000, 1'b1, rd_v);
		dev_go(15'h0004, c1(1'b1, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		chk_bit(rf_dis_n, 1'b1);
		dev_go(15'h0000, 32'h0, 1'b0, rd_v);
		chk_word(rd_v, 32'h0);
		dev_go(15'h000c, 32'h0, 1'b1, rd_v);
		dev_go(15'h0004, c1(1'b0, 1'b1, 1'b0, 2'h0, 4'h0), 1'b1, rd_v);
		chk_bit(rf_dis_n, 1'b1);
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		dev_go(15'h0000, 32'h0, 1'b0, rd_v);
		chk_word(rd_v, 32'h01600000);
		chk_bit(rf_dis_n, 1'b0);
		$display("test protection done");
		conclude();
	end
endmodule : board_control_status_regs_tb
`default_nettype wire
